// ==== rtl/servo_sup_pkg.sv ====
package servo_sup_pkg;
    // ***********************************************************
    // Register map (byte addresses on the AXI4-Lite slave)
    // ***********************************************************
    localparam logic [7:0] ADDR_HOLD_TIME = 8'h00;
    localparam logic [7:0] ADDR_OL_WARN = 8'h04;
    localparam logic [7:0] ADDR_OL_DERATE = 8'h08;
    localparam logic [7:0] ADDR_REGEN_CAP = 8'h0c;
    localparam logic [7:0] ADDR_IN_ALLOC = 8'h10;
    localparam logic [7:0] ADDR_ROT_LEVEL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_OL_ALARM_TIME = 8'h24;
    localparam logic [7:0] ADDR_OL_INST_LIMIT = 8'h28;

    // ***********************************************************
    // Reset values and limits
    // ***********************************************************
    localparam logic [15:0] HOLD_TIME_RST = 16'h0014;
    localparam logic [15:0] HOLD_TIME_MIN = 16'h0014;
    localparam logic [15:0] HOLD_TIME_MAX = 16'hc350;
    localparam logic [15:0] OL_WARN_RST = 16'h0014;
    localparam logic [15:0] OL_WARN_MIN = 16'h0001;
    localparam logic [15:0] OL_WARN_MAX = 16'h0064;
    localparam logic [15:0] OL_DERATE_RST = 16'h0064;
    localparam logic [15:0] OL_DERATE_MIN = 16'h000a;
    localparam logic [15:0] OL_DERATE_MAX = 16'h0064;
    localparam logic [15:0] REGEN_CAP_RST = 16'h0000;
    localparam logic [15:0] IN_ALLOC_RST = 16'h0000;
    localparam logic [15:0] ROT_LEVEL_RST = 16'h0014;
    localparam logic [15:0] ROT_LEVEL_MAX = 16'h2710;
    localparam logic [15:0] OL_ALARM_TIME_RST = 16'h2710;
    localparam logic [15:0] OL_INST_LIMIT_RST = 16'h012c;
    localparam logic [15:0] PERCENT_FULL = 16'h0064;

    // ***********************************************************
    // Field positions
    // ***********************************************************
    localparam int ALLOC_MODE_LSB = 0;
    localparam int ALLOC_MODE_W = 4;
    localparam int IRQ_W = 4;
    localparam int IRQ_HOLD_TRIP = 0;
    localparam int IRQ_OL_WARN = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_MAIN_BACK = 3;

    // ***********************************************************
    // Timing
    // ***********************************************************
    localparam int CLK_HZ = 125000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int CTRL_HOLDUP_MS = 100;
endpackage : servo_sup_pkg

// ==== rtl/servo_supervision.sv ====
`timescale 1ns/10ps
`default_nettype none

module servo_supervision #(
    parameter int TICK_LEN = servo_sup_pkg::TICK_CYCLES,
    parameter int NUM_IN = 8
) (
    input wire logic MCLK, // System clock
    input wire logic RST, // Synchronous reset, high
    input wire logic MAIN_PRESENT, // Main supply present
    input wire logic CTRL_PRESENT, // Control supply present
    input wire logic BASE_BLOCK, // Hardwired base block active
    input wire logic ABS_ENCODER, // Absolute encoder fitted
    input wire logic ABS_READY, // Ready for absolute data request
    input wire logic EXT_ALARM, // Other alarms in the drive
    input wire logic [15:0] MOTOR_SPEED, // Speed magnitude, min^-1
    input wire logic [15:0] LOAD_PCT, // Motor load, percent of rated
    input wire logic [15:0] REGEN_POWER, // Regen power, 10 W units
    input wire logic [NUM_IN-1:0] SEQ_IN_DEFAULT, // Default terminals
    input wire logic [NUM_IN-1:0] SEQ_IN_CUSTOM, // Custom allocation
    input wire logic [31:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Write strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [31:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY, // Read data ready
    output logic SERVO_ON, // Motor power stage enabled
    output logic SERVO_READY_OUT, // Servo ready, high = closed
    output logic ALARM_OUT, // Alarm contact, high = closed (normal)
    output logic WARN_OUT, // Warning contact, high = closed
    output logic ROTATION_DETECT_OUT, // High = faster than level
    output logic [NUM_IN-1:0] SEQ_IN, // Allocated sequence inputs
    output logic IRQ // Interrupt, level
);
    import servo_sup_pkg::*;

    // ***********************************************************
    // Types and helpers
    // ***********************************************************
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_OFF = 3'b100
    } pwr_state_e;

    function automatic logic [15:0] clamp16(input logic [15:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ***********************************************************
    // Registers
    // ***********************************************************
    logic [15:0] hold_time_reg;
    logic [15:0] ol_warn_reg;
    logic [15:0] ol_derate_reg;
    logic [15:0] regen_cap_reg;
    logic [15:0] in_alloc_reg;
    logic [15:0] rot_level_reg;
    logic [15:0] ol_alarm_time_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [15:0] derate_active_reg;
    logic alloc_custom_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic [31:0] rd_word;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_w1c;

    // ***********************************************************
    // AXI4-Lite write path: address and data accepted in any order
    // ***********************************************************
    assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY;
            S_AXI_WREADY <= !w_held_reg && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR[7:0];
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (aw_addr_reg > ADDR_OL_INST_LIMIT ||
                    aw_addr_reg[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end
        end
    end

    // Hold time, warning, derate and rotation level settings are clamped to their legal range on write
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            hold_time_reg <= HOLD_TIME_RST;
            ol_warn_reg <= OL_WARN_RST;
            ol_derate_reg <= OL_DERATE_RST;
            regen_cap_reg <= REGEN_CAP_RST;
            in_alloc_reg <= IN_ALLOC_RST;
            rot_level_reg <= ROT_LEVEL_RST;
            ol_alarm_time_reg <= OL_ALARM_TIME_RST;
            irq_mask_reg <= '0;
        end
        else if (wr_fire)
        begin
            case (aw_addr_reg)
                ADDR_HOLD_TIME: hold_time_reg <= clamp16(merge16(
                    hold_time_reg, w_data_reg, w_strb_reg),
                    HOLD_TIME_MIN, HOLD_TIME_MAX);
                ADDR_OL_WARN: ol_warn_reg <= clamp16(merge16(ol_warn_reg,
                    w_data_reg, w_strb_reg), OL_WARN_MIN, OL_WARN_MAX);
                ADDR_OL_DERATE: ol_derate_reg <= clamp16(merge16(
                    ol_derate_reg, w_data_reg, w_strb_reg),
                    OL_DERATE_MIN, OL_DERATE_MAX);
                ADDR_REGEN_CAP: regen_cap_reg <= merge16(regen_cap_reg,
                    w_data_reg, w_strb_reg);
                ADDR_IN_ALLOC: in_alloc_reg <= merge16(in_alloc_reg,
                    w_data_reg, w_strb_reg);
                ADDR_ROT_LEVEL: rot_level_reg <= clamp16(merge16(
                    rot_level_reg, w_data_reg, w_strb_reg),
                    16'h0000, ROT_LEVEL_MAX);
                ADDR_OL_ALARM_TIME: ol_alarm_time_reg <= merge16(
                    ol_alarm_time_reg, w_data_reg, w_strb_reg);
                ADDR_IRQ_MASK: irq_mask_reg <= w_data_reg[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ***********************************************************
    // Restart-effective settings: latched only in reset and the cycle after it
    // ***********************************************************
    // A soft change is stored but never acts, as reset restores the register;
    // values are taken from the registers' reset defaults at reset.
    logic restart_pend_reg;
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            restart_pend_reg <= 1'b1;
            derate_active_reg <= OL_DERATE_RST;
            alloc_custom_reg <= 1'b0;
        end
        else if (restart_pend_reg)
        begin
            restart_pend_reg <= 1'b0;
            derate_active_reg <= ol_derate_reg;
            alloc_custom_reg <=
                in_alloc_reg[ALLOC_MODE_LSB +: ALLOC_MODE_W] ==
                4'h1;
        end
    end

    // ***********************************************************
    // Millisecond tick and power-loss sequencer
    // ***********************************************************
    logic [31:0] tick_cnt_reg;
    logic tick;
    logic [15:0] outage_ms_reg;
    logic [15:0] ctrl_ms_reg;
    logic ctrl_lost_reg;
    pwr_state_e pwr_state_reg;

    assign tick = (tick_cnt_reg == 32'(TICK_LEN - 1));

    always_ff @(posedge MCLK)
    begin
        if (RST || tick)
            tick_cnt_reg <= 32'h00000000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end

    // Control supply outage past holdup acts like a normal power-off
    always_ff @(posedge MCLK)
    begin
        if (RST || CTRL_PRESENT)
        begin
            ctrl_ms_reg <= 16'h0000;
            ctrl_lost_reg <= 1'b0;
        end
        else if (tick)
        begin
            if (ctrl_ms_reg >= 16'(CTRL_HOLDUP_MS))
                ctrl_lost_reg <= 1'b1;
            else
                ctrl_ms_reg <= ctrl_ms_reg + 16'h0001;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            pwr_state_reg <= ST_OFF;
            outage_ms_reg <= 16'h0000;
        end
        else if (ctrl_lost_reg)
        begin
            pwr_state_reg <= ST_OFF;
            outage_ms_reg <= 16'h0000;
        end
        else
        begin
            case (pwr_state_reg)
                ST_RUN:
                    if (!MAIN_PRESENT)
                    begin
                        pwr_state_reg <= ST_HOLD;
                        outage_ms_reg <= 16'h0000;
                    end
                ST_HOLD:
                    if (MAIN_PRESENT)
                        pwr_state_reg <= ST_RUN;
                    else if (tick)
                    begin
                        if (outage_ms_reg >= hold_time_reg)
                            pwr_state_reg <= ST_OFF;
                        else
                            outage_ms_reg <= outage_ms_reg + 16'h0001;
                    end
                ST_OFF:
                    if (MAIN_PRESENT)
                        pwr_state_reg <= ST_RUN;
                default: pwr_state_reg <= ST_OFF;
            endcase
        end
    end

    // ***********************************************************
    // Overload and regenerative supervision
    // ***********************************************************
    // Continuous overload accumulates ms while load exceeds the
    // derated base; the instantaneous limit is not programmable.
    logic [15:0] ol_acc_reg;
    logic ol_alarm_reg;
    logic ol_inst_alarm_reg;
    logic ol_warn_flag_reg;
    logic regen_alarm_reg;
    logic [31:0] warn_limit;

    assign warn_limit = 32'(ol_alarm_time_reg) * 32'(ol_warn_reg);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            ol_acc_reg <= 16'h0000;
            ol_alarm_reg <= 1'b0;
            ol_inst_alarm_reg <= 1'b0;
            ol_warn_flag_reg <= 1'b0;
            regen_alarm_reg <= 1'b0;
        end
        else
        begin
            if (LOAD_PCT >= OL_INST_LIMIT_RST)
                ol_inst_alarm_reg <= 1'b1;
            if (tick)
            begin
                if (LOAD_PCT > derate_active_reg)
                begin
                    if (ol_acc_reg != 16'hffff)
                        ol_acc_reg <= ol_acc_reg + 16'h0001;
                end
                else if (ol_acc_reg != 16'h0000)
                    ol_acc_reg <= ol_acc_reg - 16'h0001;
            end
            if (ol_acc_reg >= ol_alarm_time_reg)
                ol_alarm_reg <= 1'b1;
            ol_warn_flag_reg <= 32'(ol_acc_reg) * 32'(PERCENT_FULL) >=
                warn_limit;
            if (regen_cap_reg != 16'h0000 && REGEN_POWER > regen_cap_reg)
                regen_alarm_reg <= 1'b1;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    logic any_alarm;
    assign any_alarm = EXT_ALARM || ol_alarm_reg || ol_inst_alarm_reg ||
        regen_alarm_reg;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            SERVO_ON <= 1'b0;
            SERVO_READY_OUT <= 1'b0;
            ALARM_OUT <= 1'b0;
            WARN_OUT <= 1'b0;
            ROTATION_DETECT_OUT <= 1'b0;
            SEQ_IN <= '0;
        end
        else
        begin
            SERVO_ON <= pwr_state_reg != ST_OFF && !any_alarm;
            SERVO_READY_OUT <= pwr_state_reg != ST_OFF && MAIN_PRESENT &&
                !BASE_BLOCK && !any_alarm &&
                (!ABS_ENCODER || ABS_READY);
            ALARM_OUT <= !any_alarm;
            WARN_OUT <= ol_warn_flag_reg && !any_alarm;
            if (MOTOR_SPEED > rot_level_reg)
                ROTATION_DETECT_OUT <= 1'b1;
            else if (MOTOR_SPEED < rot_level_reg)
                ROTATION_DETECT_OUT <= 1'b0;
            SEQ_IN <= alloc_custom_reg ? SEQ_IN_CUSTOM :
                SEQ_IN_DEFAULT;
        end
    end

    // ***********************************************************
    // Interrupts: set wins over a write-one-to-clear
    // ***********************************************************
    logic alarm_d_reg;
    logic main_d_reg;
    logic hold_trip;
    assign hold_trip = pwr_state_reg == ST_HOLD && tick && !MAIN_PRESENT &&
        outage_ms_reg >= hold_time_reg;
    assign irq_event = {MAIN_PRESENT && !main_d_reg,
        any_alarm && !alarm_d_reg, ol_warn_flag_reg, hold_trip};
    assign irq_w1c = (wr_fire && aw_addr_reg == ADDR_IRQ_STAT) ?
        w_data_reg[IRQ_W-1:0] : '0;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            irq_stat_reg <= '0;
            alarm_d_reg <= 1'b0;
            main_d_reg <= 1'b1;
            IRQ <= 1'b0;
        end
        else
        begin
            alarm_d_reg <= any_alarm;
            main_d_reg <= MAIN_PRESENT;
            irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_event;
            IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ***********************************************************
    // AXI4-Lite read path
    // ***********************************************************
    always_comb
    begin
        case (S_AXI_ARADDR[7:0])
            ADDR_HOLD_TIME: rd_word = {16'h0000, hold_time_reg};
            ADDR_OL_WARN: rd_word = {16'h0000, ol_warn_reg};
            ADDR_OL_DERATE: rd_word = {16'h0000, ol_derate_reg};
            ADDR_REGEN_CAP: rd_word = {16'h0000, regen_cap_reg};
            ADDR_IN_ALLOC: rd_word = {16'h0000, in_alloc_reg};
            ADDR_ROT_LEVEL: rd_word = {16'h0000, rot_level_reg};
            ADDR_STATUS: rd_word = {16'h0000, ol_acc_reg[7:0],
                pwr_state_reg, regen_alarm_reg, ol_inst_alarm_reg,
                ol_alarm_reg, ol_warn_flag_reg, ctrl_lost_reg};
            ADDR_IRQ_STAT: rd_word = {28'h0000000, irq_stat_reg};
            ADDR_IRQ_MASK: rd_word = {28'h0000000, irq_mask_reg};
            ADDR_OL_ALARM_TIME: rd_word = {16'h0000, ol_alarm_time_reg};
            ADDR_OL_INST_LIMIT: rd_word = {16'h0000, OL_INST_LIMIT_RST};
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'h0;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY &&
                S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_word;
                S_AXI_RRESP <= (S_AXI_ARADDR[7:0] > ADDR_OL_INST_LIMIT ||
                    S_AXI_ARADDR[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end
endmodule : servo_supervision

`default_nettype wire

// ==== verification/servo_sup_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module servo_sup_sva #(
    parameter int TICK_LEN = 10
) (
    input wire logic MCLK, // Clock
    input wire logic RST, // Reset
    input wire logic MAIN_PRESENT, // Main supply
    input wire logic CTRL_PRESENT, // Control supply
    input wire logic BASE_BLOCK, // Base block
    input wire logic ABS_ENCODER, // Absolute encoder
    input wire logic ABS_READY, // Data request ready
    input wire logic EXT_ALARM, // Other alarm
    input wire logic [15:0] MOTOR_SPEED, // Speed
    input wire logic [15:0] LOAD_PCT, // Load
    input wire logic SERVO_ON, // Motor powered
    input wire logic SERVO_READY_OUT, // Ready
    input wire logic ALARM_OUT, // Alarm contact
    input wire logic ROTATION_DETECT_OUT // Rotation
);
    int low_cnt;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // Free-running tick phase gives up to one ms of slack either way
    always_ff @(posedge MCLK)
        low_cnt <= (RST || MAIN_PRESENT) ? 0 : low_cnt + 1;
    sequence main_back;
        $rose(MAIN_PRESENT) && CTRL_PRESENT && ALARM_OUT;
    endsequence
    alarm_ext_a: assert property (EXT_ALARM |=> !ALARM_OUT)
        else $error("alarm contact stayed closed");
    inst_limit_a: assert property (LOAD_PCT >= 16'h012c |->
        ##[1:4] !ALARM_OUT)
        else $error("instantaneous overload missed");
    block_ready_a: assert property (BASE_BLOCK |=> !SERVO_READY_OUT)
        else $error("ready during base block");
    abs_ready_a: assert property (ABS_ENCODER && !ABS_READY |=>
        !SERVO_READY_OUT)
        else $error("ready before data request readiness");
    rot_rise_a: assert property ($rose(ROTATION_DETECT_OUT) |->
        $past(MOTOR_SPEED) != 16'h0000)
        else $error("rotation flagged at standstill");
    rot_fall_a: assert property ($fell(ROTATION_DETECT_OUT) |->
        $past(MOTOR_SPEED) < 16'h2710)
        else $error("rotation cleared above top level");
    trip_ready_a: assert property ($fell(SERVO_ON) |->
        !SERVO_READY_OUT)
        else $error("ready kept after servo off");
    hold_min_a: assert property ($fell(SERVO_ON) &&
        !MAIN_PRESENT && ALARM_OUT |-> low_cnt >= 19 * TICK_LEN)
        else $error("servo dropped before hold time");
    hold_max_a: assert property (SERVO_ON |->
        low_cnt <= 22 * TICK_LEN)
        else $error("servo kept past hold time");
    back_on_a: assert property (main_back |-> ##[1:4] SERVO_ON)
        else $error("servo not restored");
endmodule : servo_sup_sva
bind servo_supervision servo_sup_sva #(.TICK_LEN(TICK_LEN)) sva (.*);
`default_nettype wire

// ==== verification/servo_supervision_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module servo_supervision_tb_top;
    import servo_sup_pkg::*;
    localparam int TL = 10;
    logic mclk, rst, main_ok, ctrl_ok, blk, abs_en, abs_rdy, ext_al;
    logic [15:0] speed, load, regen, s16;
    logic [7:0] sdef, scus, seqin;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic [1:0] bresp, rresp, rr;
    logic son, srdy, alarm_out, warn, rot, irq, rexp;
    int err_count = 0;
    int n_checks = 0;
    int lvl, sp;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rv [6] = '{32'h14, 32'h14, 32'h64, 32'h0, 32'h0, 32'h14};
    supply_model sup (.MCLK(mclk), .main_ok(main_ok), .ctrl_ok(ctrl_ok));
    servo_supervision #(.TICK_LEN(TL), .NUM_IN(8)) dut (
        .MCLK(mclk), .RST(rst), .MAIN_PRESENT(main_ok), .CTRL_PRESENT(ctrl_ok),
        .BASE_BLOCK(blk), .ABS_ENCODER(abs_en), .ABS_READY(abs_rdy),
        .EXT_ALARM(ext_al), .MOTOR_SPEED(speed), .LOAD_PCT(load),
        .REGEN_POWER(regen), .SEQ_IN_DEFAULT(sdef), .SEQ_IN_CUSTOM(scus),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SERVO_ON(son),
        .SERVO_READY_OUT(srdy), .ALARM_OUT(alarm_out), .WARN_OUT(warn),
        .ROTATION_DETECT_OUT(rot), .SEQ_IN(seqin), .IRQ(irq));
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    // Ready is looked at mid-cycle, release happens at the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh;
        @(posedge mclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        {awv, wv, bready} <= 3'b111;
        do
        begin
            @(negedge mclk);
            ah = awv && awrdy === 1'b1;
            wh = wv && wrdy === 1'b1;
            @(posedge mclk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
        end
        while (!((ah || !awv) && (wh || !wv)));
        do @(negedge mclk); while (bvalid !== 1'b1);
        @(posedge mclk) bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        araddr <= {24'h0, a};
        {arv, rready} <= 2'b11;
        do @(negedge mclk); while (arrdy !== 1'b1);
        @(posedge mclk) arv <= 1'b0;
        do @(negedge mclk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        @(posedge mclk) rready <= 1'b0;
    endtask : rdr
    task automatic rdc(input string nm, input logic [7:0] a, logic [31:0] e);
        rdr(a);
        chk(nm, e, rd);
    endtask : rdc
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        #(20000 * 8);
        err_count++;
        complete_run();
    end
    initial
    begin
        void'($urandom(3));
        {rst, blk, abs_en, abs_rdy, ext_al, awv, wv, bready, arv,
            rready} = 10'h200;
        {speed, load, regen, awaddr, wdata, araddr} = '0;
        regen = 16'hffff;
        sdef = 8'($urandom);
        scus = ~sdef;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
            rdc("reset value", ra[i], rv[i]);
        wr(ADDR_HOLD_TIME, 32'h5);
        rdc("hold low clamp", ADDR_HOLD_TIME, 32'h14);
        wr(ADDR_HOLD_TIME, 32'hffff);
        rdc("hold high clamp", ADDR_HOLD_TIME, 32'hc350);
        wr(ADDR_HOLD_TIME, 32'h14);
        rdr(8'h40);
        chk("unmapped resp", 32'h2, rr);
        wr(ADDR_IN_ALLOC, 32'h1);
        cyc(2);
        chk("seq in", sdef, seqin);
        chk("alarm idle", 1, alarm_out);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk) {blk, abs_en, abs_rdy} <= 3'(i);
            cyc(4);
            chk("ready", !blk && (!abs_en || abs_rdy), srdy);
        end
        rexp = 1'b0;
        for (int j = 0; j < 24; j++)
        begin
            if (j % 4 == 0) lvl = $urandom_range(10000);
            if (j % 4 == 0) wr(ADDR_ROT_LEVEL, 32'(lvl));
            sp = (j % 4 == 0) ? lvl + 3 : lvl + int'($urandom_range(4)) - 2;
            s16 = sp[15:0];
            @(posedge mclk) speed <= s16;
            cyc(3);
            if (s16 > lvl[15:0]) rexp = 1'b1;
            else if (s16 < lvl[15:0]) rexp = 1'b0;
            chk("rotation", rexp, rot);
        end
        sup.off_for(18 * TL);
        cyc(1);
        chk("servo short gap", 1, son);
        sup.back();
        sup.off_for(25 * TL);
        cyc(1);
        chk("servo long gap", 0, son);
        chk("ready long gap", 0, srdy);
        sup.back();
        cyc(4);
        chk("servo back", 1, son);
        sup.off_for(105 * TL, 1'b1);
        cyc(1);
        chk("servo ctrl loss", 0, son);
        sup.back();
        rdc("irq status", ADDR_IRQ_STAT, 32'h9);
        chk("irq masked", 0, irq);
        wr(ADDR_IRQ_MASK, 32'h8);
        cyc(2);
        chk("irq on", 1, irq);
        wr(ADDR_IRQ_STAT, 32'h9);
        cyc(2);
        chk("irq cleared", 0, irq);
        @(posedge mclk) ext_al <= 1'b1;
        cyc(3);
        chk("alarm ext", 0, alarm_out);
        wr(ADDR_OL_ALARM_TIME, 32'h14);
        wr(ADDR_OL_WARN, 32'h32);
        @(posedge mclk) {ext_al, load} <= {1'b0, 16'h0096};
        cyc(8 * TL);
        chk("warn early", 0, warn);
        cyc(5 * TL);
        chk("warn on", 1, warn);
        chk("alarm at warn", 1, alarm_out);
        cyc(12 * TL);
        chk("overload alarm", 0, alarm_out);
        chk("ready on alarm", 0, srdy);
        @(posedge mclk) load <= 16'h012c;
        cyc(3);
        complete_run();
    end
endmodule : servo_supervision_tb_top
`default_nettype wire

// ==== verification/supply_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module supply_model (
    input wire logic MCLK, // Clock
    output logic main_ok, // Main supply present
    output logic ctrl_ok // Control supply present
);
    initial main_ok = 1'b1;
    initial ctrl_ok = 1'b1;
    // Supply stays low on return so the bench can look before restoring
    task automatic off_for(input int n, input bit c = 1'b0);
        @(posedge MCLK) {main_ok, ctrl_ok} <= {c, !c};
        repeat (n) @(posedge MCLK);
    endtask : off_for
    task automatic back;
        @(posedge MCLK) {main_ok, ctrl_ok} <= 2'b11;
    endtask : back
endmodule : supply_model
`default_nettype wire
